/* core/apspc_ctrl.sv */
// Function
// - Non-secure output follows control bit 30, reset one.
// - Access allowed only with port enable and (secure enable or non-secure set).
// - Protection output 4:0 from field 28:24, bit 6 from shareable bit.
// - Protection output bit 5 is always low.
// - Reset loads protection field three, shareable bit zero.
// - Status bit 23 set only when both enable inputs high.
// - Secure transfers blocked while secure status clear; others still allowed while port enable is high and no sticky error is set.
// - Halt-on-error bit 17 blocks accesses after a memory error.
// - Shareable bit 15 drives protection bit 6, resets zero.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module apspc_ctrl
  import apspc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic port_enable_in_i,
  input wire logic secure_enable_in_i,
  input wire logic mem_error_i,
  output logic nonsec_o,
  output logic [6:0] prot_o,
  output logic access_ok_o,
  output logic secure_access_ok_status_o
);
  // Enable inputs come from another domain: two-stage synchronisers
  logic [1:0] pen_sync;
  logic [1:0] sen_sync;
  logic [1:0] next_pen_sync;
  logic [1:0] next_sen_sync;
  logic pen;
  logic sen;
  // Shift one stage per clock; only the second stage feeds any logic
  always_comb begin
    next_pen_sync = {pen_sync[0], port_enable_in_i};
    next_sen_sync = {sen_sync[0], secure_enable_in_i};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pen_sync <= 2'h0;
      sen_sync <= 2'h0;
    end else begin
      pen_sync <= next_pen_sync;
      sen_sync <= next_sen_sync;
    end
  end
  assign pen = pen_sync[1];
  assign sen = sen_sync[1];

  // Control state
  logic nonsec;
  logic [4:0] prot;
  logic share;
  logic halt_on_error;
  logic err_stuck;
  logic blocked;
  logic granted;
  apspc_bus_t bus_st;
  logic next_nonsec;
  logic [4:0] next_prot;
  logic next_share;
  logic next_halt;
  logic next_stuck;
  logic next_blocked;
  logic next_granted;
  apspc_bus_t next_bus_st;
  logic [31:0] next_dat;
  logic next_ack;

  // Decode of one register select, used for writes and reads
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a[11:2] == r[11:2]);
  endfunction

  logic secure_ok;
  logic permit;
  logic take_now;
  logic wr_now;
  logic attempt_now;
  logic clear_now;
  assign secure_ok = pen & sen;
  assign permit = pen & (sen | nonsec);
  // Ack on the cycle after the strobe; the cycle spent in APSPC_ACK that follows drops ack
  assign take_now = wb_cyc_i & wb_stb_i & (bus_st == APSPC_IDLE);
  assign wr_now = take_now & wb_we_i;
  // Request register strobes; byte lane 0 carries both command bits
  assign attempt_now = wr_now & hit(wb_adr_i, APSPC_REQ_ADDR) & wb_sel_i[0] &
    wb_dat_i[APSPC_REQ_GO_BIT];
  assign clear_now = wr_now & hit(wb_adr_i, APSPC_REQ_ADDR) & wb_sel_i[0] &
    wb_dat_i[APSPC_REQ_CLR_BIT];

  // Next-state logic for registers and the access check
  always_comb begin
    next_nonsec = nonsec;
    next_prot = prot;
    next_share = share;
    next_halt = halt_on_error;
    next_stuck = err_stuck;
    // The outcome of the last attempt stays readable until the next one
    next_blocked = blocked;
    next_granted = granted;
    next_bus_st = APSPC_IDLE;
    next_ack = 1'b0;
    next_dat = 32'h0;
    // Sticky error: set wins over a clear in the same cycle
    if (clear_now) begin
      next_stuck = 1'b0;
    end
    if (mem_error_i && halt_on_error) begin
      next_stuck = 1'b1;
    end
    case (bus_st)
      APSPC_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          // Writes land at the same edge that raises ack; a read shows the old value
          next_bus_st = APSPC_ACK;
          next_ack = 1'b1;
          if (hit(wb_adr_i, APSPC_CSW_ADDR)) begin
            if (wb_we_i) begin
              // Only the implemented bits store; the rest are dropped
              if (wb_sel_i[3]) begin
                next_nonsec = wb_dat_i[APSPC_NONSEC_BIT];
                next_prot = wb_dat_i[APSPC_PROT_HI:APSPC_PROT_LO];
              end
              if (wb_sel_i[2]) begin
                next_halt = wb_dat_i[APSPC_HALT_BIT];
              end
              if (wb_sel_i[1]) begin
                next_share = wb_dat_i[APSPC_SHARE_BIT];
              end
            end
            // Reserved bits 31, 29, 22:18 stay zero
            next_dat[APSPC_NONSEC_BIT] = nonsec;
            next_dat[APSPC_PROT_HI:APSPC_PROT_LO] = prot;
            next_dat[APSPC_SECOK_BIT] = secure_ok;
            next_dat[APSPC_HALT_BIT] = halt_on_error;
            next_dat[APSPC_SHARE_BIT] = share;
          end else if (hit(wb_adr_i, APSPC_REQ_ADDR)) begin
            if (attempt_now) begin
              // A memory access is attempted: grant or block it
              if (permit && !err_stuck) begin
                next_granted = 1'b1;
                next_blocked = 1'b0;
              end else begin
                next_granted = 1'b0;
                next_blocked = 1'b1;
              end
            end
            next_dat[APSPC_ST_OK_BIT] = permit;
            next_dat[APSPC_ST_BLK_BIT] = blocked;
            next_dat[APSPC_ST_STK_BIT] = err_stuck;
          end
        end
      end
      APSPC_ACK: begin
        next_bus_st = APSPC_IDLE;
      end
      default: begin
        next_bus_st = APSPC_IDLE;
      end
    endcase
  end

  // Register stage; reset gives non-secure privileged data attributes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nonsec <= APSPC_NONSEC_RST;
      prot <= APSPC_PROT_RST;
      share <= APSPC_SHARE_RST;
      halt_on_error <= APSPC_HALT_RST;
      err_stuck <= 1'b0;
      blocked <= 1'b0;
      granted <= 1'b0;
      bus_st <= APSPC_IDLE;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
    end else begin
      nonsec <= next_nonsec;
      prot <= next_prot;
      share <= next_share;
      halt_on_error <= next_halt;
      err_stuck <= next_stuck;
      blocked <= next_blocked;
      granted <= next_granted;
      bus_st <= next_bus_st;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end

  // Outputs registered so they come straight from flip-flops
  apspc_attr_t next_attr;
  logic next_access_ok;
  logic next_secure_status;
  always_comb begin
    next_attr.nonsec = next_nonsec;
    next_attr.prot = {next_share, 1'b0, next_prot};
    // Registering costs one cycle, so access_ok_o trails permit and the synced enables
    next_access_ok = permit & ~err_stuck;
    next_secure_status = secure_ok;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nonsec_o <= APSPC_NONSEC_RST;
      prot_o <= {APSPC_SHARE_RST, 1'b0, APSPC_PROT_RST};
      access_ok_o <= 1'b0;
      secure_access_ok_status_o <= 1'b0;
    end else begin
      nonsec_o <= next_attr.nonsec;
      prot_o <= next_attr.prot;
      access_ok_o <= next_access_ok;
      secure_access_ok_status_o <= next_secure_status;
    end
  end

  // Assertions
  bit_five_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    prot_o[5] == 1'b0) else $error("prot bit 5 driven high");
  prot_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    prot_o == {share, 1'b0, prot}) else $error("prot output mismatch");
  nonsec_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    nonsec_o == nonsec) else $error("nonsec output mismatch");
  permit_rule_a: assert property (@(posedge clk_i) disable iff (rst_i)
    access_ok_o == $past(pen & (sen | nonsec) & ~err_stuck))
    else $error("access permit wrong");
  secure_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    secure_access_ok_status_o == $past(pen & sen)) else $error("secure status wrong");
  secure_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!secure_ok && !nonsec) |=> !access_ok_o) else $error("secure access not blocked");
  halt_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_error_i && halt_on_error) |=> err_stuck ##1 !access_ok_o)
    else $error("error did not halt");
  no_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!halt_on_error && !err_stuck) |=> !err_stuck) else $error("stuck without halt");
  // Checked on the first edge after release, never on the unknown state before reset
  reset_val_a: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i) |-> (prot == 5'h03 && !share && nonsec))
    else $error("reset values wrong");
  raz_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> (wb_dat_o[31] == 1'b0 && wb_dat_o[29] == 1'b0 && wb_dat_o[22:18] == 5'h00))
    else $error("reserved bits nonzero");
  share_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    prot_o[6] == share) else $error("shareable bit not driven");
  ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  // Attempt outcome and sticky error
  grant_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    attempt_now |=> (granted == $past(permit && !err_stuck) && blocked == !granted))
    else $error("attempt outcome wrong");
  outcome_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(granted && blocked)) else $error("grant and block together");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (clear_now && mem_error_i && halt_on_error) |=> err_stuck)
    else $error("clear beat a new error");
  stuck_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (clear_now && !(mem_error_i && halt_on_error)) |=> !err_stuck)
    else $error("sticky error not cleared");
  sticky_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (err_stuck && !clear_now) |=> err_stuck)
    else $error("sticky error lost");
  stuck_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    err_stuck |=> !access_ok_o) else $error("access let through while halted");

  // Bus timing: a taken request is answered on the next cycle only
  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take_now |=> wb_ack_o) else $error("request not acknowledged");
  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(take_now)) else $error("ack without request");

  // Read data shows the state as it stood when the request was taken
  csw_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_now && hit(wb_adr_i, APSPC_CSW_ADDR)) |=>
    (wb_dat_o[APSPC_NONSEC_BIT] == $past(nonsec) &&
    wb_dat_o[APSPC_PROT_HI:APSPC_PROT_LO] == $past(prot)))
    else $error("control word readback wrong");
  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_now && hit(wb_adr_i, APSPC_CSW_ADDR)) |=>
    wb_dat_o[APSPC_SECOK_BIT] == $past(pen && sen))
    else $error("secure status readback wrong");
  req_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_now && hit(wb_adr_i, APSPC_REQ_ADDR)) |=>
    wb_dat_o[2:0] == $past({err_stuck, blocked, permit}))
    else $error("request status readback wrong");
  unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_now && !hit(wb_adr_i, APSPC_CSW_ADDR) && !hit(wb_adr_i, APSPC_REQ_ADDR)) |=>
    wb_dat_o == 32'h0) else $error("unmapped read not zero");

  // Outputs straight after reset release
  reset_out_a: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i) |->
    (nonsec_o && prot_o == {APSPC_SHARE_RST, 1'b0, APSPC_PROT_RST} && !access_ok_o))
    else $error("outputs not at reset values");
endmodule // apspc_ctrl
`default_nettype wire

/* inc/apspc_pkg.sv */
`default_nettype none
package apspc_pkg;
  // Register byte address of the control word on the Wishbone slave
  localparam logic [11:0] APSPC_CSW_ADDR = 12'hd00;
  // Offset of the access request / status register
  localparam logic [11:0] APSPC_REQ_ADDR = 12'hd04;
  // Field positions in the control word
  localparam int APSPC_NONSEC_BIT = 30;
  localparam int APSPC_PROT_HI = 28;
  localparam int APSPC_PROT_LO = 24;
  localparam int APSPC_SECOK_BIT = 23;
  localparam int APSPC_HALT_BIT = 17;
  localparam int APSPC_SHARE_BIT = 15;
  // Reset values
  localparam logic APSPC_NONSEC_RST = 1'h1;
  localparam logic [4:0] APSPC_PROT_RST = 5'h03;
  localparam logic APSPC_SHARE_RST = 1'h0;
  localparam logic APSPC_HALT_RST = 1'h0;
  // Request register field positions
  localparam int APSPC_REQ_GO_BIT = 0;
  localparam int APSPC_REQ_ERR_BIT = 1;
  localparam int APSPC_REQ_CLR_BIT = 2;
  localparam int APSPC_ST_OK_BIT = 0;
  localparam int APSPC_ST_BLK_BIT = 1;
  localparam int APSPC_ST_STK_BIT = 2;
  // Attributes presented to the master side
  typedef struct packed {
    logic nonsec;
    logic [6:0] prot;
  } apspc_attr_t;
  typedef enum logic [1:0] {
    APSPC_IDLE = 2'b00,
    APSPC_ACK = 2'b01
  } apspc_bus_t;
endpackage
`default_nettype wire

/* test/apspc_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Memory side: answers a let-through transfer with an error when told to
module apspc_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fail_i,
  input wire logic access_ok_i,
  output logic mem_error_o
);
  // Only a transfer that was let through can come back with an error
  always_ff @(posedge clk_i) begin
    mem_error_o <= !rst_i && fail_i && access_ok_i;
  end
endmodule // apspc_mem_model
`default_nettype wire

/* test/test_apspc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module test_apspc_ctrl
  import apspc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic pen = 1'b0;
  logic sen = 1'b0;
  logic fail = 1'b0;
  logic [31:0] rdat, rd;
  logic ack, merr, nonsec, aok, sok;
  logic [6:0] prot;
  int failures = 0;
  int cmp_count = 0;
  apspc_ctrl apspc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_enable_in_i(pen), .secure_enable_in_i(sen), .mem_error_i(merr),
    .nonsec_o(nonsec), .prot_o(prot), .access_ok_o(aok), .secure_access_ok_status_o(sok));
  apspc_mem_model apspc_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .fail_i(fail),
    .access_ok_i(aok), .mem_error_o(merr));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic conclude();
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic cycle: everything held until ack is seen at an edge
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= s;
    cyc <= 1'b1;
    // Ack is looked at mid-cycle, where it stands settled up to the next edge
    do begin
      @(negedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    @(posedge clk_i);
    cyc <= 1'b0;
    if (n >= 20) begin
      failures++;
      conclude();
    end
  endtask
  // Enables pass a two-flop synchroniser, so give them time to land
  task automatic settle(input logic p, input logic s);
    @(posedge clk_i);
    pen <= p;
    sen <= s;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic pulse_fail();
    @(posedge clk_i);
    fail <= 1'b1;
    @(posedge clk_i);
    fail <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_reset();
    bus(APSPC_CSW_ADDR, 1'b0, 32'h0, 4'hf);
    chk("csw", 32'h43000000, rd & 32'hfffe8000);
    chk("prot", 32'h03, {25'h0, prot});
    chk("nonsec", 32'h1, {31'h0, nonsec});
  endtask
  // Reserved bits stay zero; a missing byte lane leaves its bits alone
  task automatic t_fields();
    bus(APSPC_CSW_ADDR, 1'b1, 32'hffffffff, 4'hf);
    bus(12'hd08, 1'b1, 32'hffffffff, 4'hf);
    bus(12'hd08, 1'b0, 32'h0, 4'hf);
    chk("unmapped", 32'h0, rd);
    bus(APSPC_CSW_ADDR, 1'b0, 32'h0, 4'hf);
    chk("csw", 32'h5f028000, rd & 32'hfffe8000);
    chk("prot", 32'h5f, {25'h0, prot});
    bus(APSPC_CSW_ADDR, 1'b1, 32'h0, 4'h7);
    chk("prot", 32'h1f, {25'h0, prot});
    bus(APSPC_CSW_ADDR, 1'b1, 32'h0, 4'hf);
    chk("prot", 32'h00, {25'h0, prot});
    chk("nonsec", 32'h0, {31'h0, nonsec});
  endtask
  // Every mix of the two enables and the non-secure bit, with an attempt each
  task automatic t_permit();
    logic e;
    logic s;
    for (int i = 0; i < 8; i++) begin
      e = i[2] & (i[1] | i[0]);
      s = i[2] & i[1];
      bus(APSPC_CSW_ADDR, 1'b1, {1'b0, i[0], 1'b0, 5'h03, 24'h0}, 4'hf);
      settle(i[2], i[1]);
      chk("access", {31'h0, e}, {31'h0, aok});
      chk("status", {31'h0, s}, {31'h0, sok});
      bus(APSPC_CSW_ADDR, 1'b0, 32'h0, 4'hf);
      chk("csw", {1'b0, i[0], 1'b0, 5'h03, s, 23'h0}, rd & 32'hfffe8000);
      bus(APSPC_REQ_ADDR, 1'b1, 32'h1, 4'hf);
      bus(APSPC_REQ_ADDR, 1'b0, 32'h0, 4'hf);
      chk("attempt", {30'h0, !e, e}, rd & 32'h7);
    end
  endtask
  // Software only uses the supported memory types
  task automatic t_types();
    logic [3:0] mt [8] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'ha, 4'he, 4'hf};
    for (int i = 0; i < 8; i++) begin
      bus(APSPC_CSW_ADDR, 1'b1, {3'h2, mt[i][2:0], 2'h3, 8'h0, mt[i][3], 15'h0}, 4'hf);
      chk("prot", {25'h0, mt[i][3], 1'b0, mt[i][2:0], 2'h3}, {25'h0, prot});
    end
  endtask
  task automatic t_halt();
    bus(APSPC_CSW_ADDR, 1'b1, 32'h43020000, 4'hf);
    settle(1'b1, 1'b1);
    pulse_fail();
    chk("halted", 32'h0, {31'h0, aok});
    // An attempt while halted is blocked, and the sticky error reads back
    bus(APSPC_REQ_ADDR, 1'b1, 32'h1, 4'hf);
    bus(APSPC_REQ_ADDR, 1'b0, 32'h0, 4'hf);
    chk("stuck", 32'h7, rd & 32'h7);
    bus(APSPC_REQ_ADDR, 1'b1, 32'h4, 4'hf);
    repeat (3) @(posedge clk_i);
    chk("cleared", 32'h1, {31'h0, aok});
    bus(APSPC_REQ_ADDR, 1'b0, 32'h0, 4'hf);
    chk("after clear", 32'h3, rd & 32'h7);
    bus(APSPC_CSW_ADDR, 1'b1, 32'h43000000, 4'hf);
    pulse_fail();
    chk("no halt", 32'h1, {31'h0, aok});
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_permit();
    t_types();
    t_halt();
    conclude();
  end
endmodule // test_apspc_ctrl
`default_nettype wire
